// >>> core/bmp_regs.svh
// Constants for the buffer memory port: widths and timing counts.
// Included by the package users; holds definitions only.
`ifndef BMP_REGS_SVH
`define BMP_REGS_SVH
`define BMP_ADDR_LOW_W 16
`define BMP_DATA_W 8
`define BMP_CLK_PERIOD_NS 4
`define BMP_ACCESS_NS 12
`define BMP_ACCESS_CYC (((`BMP_ACCESS_NS) + (`BMP_CLK_PERIOD_NS) - 1) / (`BMP_CLK_PERIOD_NS))
`define BMP_PKT_BITS 32
`define BMP_APPLY_CYC 2
`endif

// >>> core/bmp_pkg.sv
// Types shared by the buffer memory port and its vector receiver.
// Assumes the constant header is on the include path.
`include "bmp_regs.svh"
package bmp_pkg;
   // Access request from the buffer manager
   typedef struct packed {
      logic wr;
      logic [17:0] addr;
      logic [7:0] data;
   } bmp_req_t;
   // Access answer to the buffer manager
   typedef struct packed {
      logic [7:0] data;
      logic par_err;
   } bmp_rsp_t;
   // Received correction vector: 24-bit offset and 8-bit pattern
   typedef struct packed {
      logic [23:0] offset;
      logic [7:0] pattern;
   } bmp_vec_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ROW = 5'h02,
      ST_COL = 5'h04,
      ST_DATA = 5'h08,
      ST_DONE = 5'h10
   } bmp_state_t;
endpackage

// >>> core/bmp_vec_rx.sv
// Serial receiver for correction vector packets on the single vector line.
// Assumes the line is already synchronised to the system clock.
`timescale 1ns/1ns
`include "bmp_regs.svh"
module bmp_vec_rx
   import bmp_pkg::*;
#(
   parameter int PKT_BITS = `BMP_PKT_BITS
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic vec_in,
   output logic frame_err_out,
   output logic valid_out,
   output bmp_vec_t vec_out
);
   logic [5:0] count;
   logic busy;
   logic [PKT_BITS-1:0] shreg;

   // ----------------------------------------
   // Framing: start bit 1, PKT_BITS data, stop bit 1
   // ----------------------------------------
   // The start bit is taken only while enabled; once busy, the remaining bits are taken regardless of enable
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count <= 6'h00;
         busy <= 1'b0;
         shreg <= '0;
         valid_out <= 1'b0;
         frame_err_out <= 1'b0;
         vec_out <= '0;
      end else begin
         valid_out <= 1'b0;
         frame_err_out <= 1'b0;
         if (!busy) begin
            if (enable_in && vec_in) begin
               busy <= 1'b1;
               count <= 6'h00;
            end
         end else if (count == 6'(PKT_BITS)) begin
            busy <= 1'b0;
            if (vec_in) begin
               valid_out <= 1'b1;
               vec_out <= shreg;
            end else begin
               frame_err_out <= 1'b1; // Missing stop bit
            end
         end else begin
            shreg <= {shreg[PKT_BITS-2:0], vec_in};
            count <= count + 6'h01;
         end
      end
   end
endmodule

// >>> core/bmp_port.sv
// Buffer memory port: drives SRAM or DRAM buffer and takes correction vectors.
// Assumes a buffer manager on the same clock issuing one request at a time.
//
// Contract
// - Shared pin is address bit 17 in SRAM, active-low column strobe in DRAM.
// - Shared pin is address bit 16 in SRAM, active-low row strobe in DRAM.
// - SRAM mode: output enable low during every access, read or write.
// - DRAM mode: output enable low only on reads, high on writes.
// - Write enable low during the data phase of a write, both modes; high in the DRAM row and column phases.
// - Data path is an 8-bit bidirectional bus.
// - Ninth line carries odd parity; generated on write, checked only on buffer manager reads.
// - Sixteen dedicated address outputs used in both modes.
// - All access and vector sequencing runs from the single system clock.
// - Ready output high whenever a new vector packet can be taken.
// - Error output on packet protocol error or failed correction.
`timescale 1ns/1ns
`include "bmp_regs.svh"
module bmp_port
   import bmp_pkg::*;
#(
   parameter int ACCESS_CYC = `BMP_ACCESS_CYC,
   parameter int BUF_TOP = 24'h03FFFF
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic dram_mode_in,
   input wire logic req_valid_in,
   input wire bmp_req_t req_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output bmp_rsp_t rsp_out,
   input wire logic vec_ack_in,
   output logic vec_valid_out,
   output bmp_vec_t vec_out,
   output logic [15:0] buffer_addr_low_out,
   output logic addr_hi17_or_col_strobe_out,
   output logic addr_hi16_or_row_strobe_out,
   output logic mem_output_enable_n_out,
   output logic mem_write_enable_n_out,
   input wire logic [7:0] buffer_data_bus_in,
   output logic [7:0] buffer_data_bus_out,
   output logic buffer_data_bus_oe_n_out,
   input wire logic buffer_data_parity_in,
   output logic buffer_data_parity_out,
   output logic buffer_data_parity_oe_n_out,
   input wire logic vector_in,
   output logic corr_accept_ready_out,
   output logic corr_fail_out
);
   // Odd parity: the ninth bit makes the count of ones odd
   function automatic logic odd_par(input logic [7:0] d);
      odd_par = ~(^d);
   endfunction

   // ----------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   logic vec_s1, vec_s2;
   logic [8:0] rd_s1, rd_s2;
   // Reset released through two stages; vector and read data pass two flops
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         vec_s1 <= 1'b0;
         vec_s2 <= 1'b0;
         rd_s1 <= 9'h000;
         rd_s2 <= 9'h000;
      end else begin
         vec_s1 <= vector_in;
         vec_s2 <= vec_s1;
         rd_s1 <= {buffer_data_parity_in, buffer_data_bus_in};
         rd_s2 <= rd_s1;
      end
   end

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   bmp_state_t state;
   logic [3:0] wait_cnt;
   bmp_req_t cur;
   logic mode;
   logic vec_pend;
   logic vec_owner;
   logic [23:0] vec_off;
   logic [7:0] vec_pat;

   // A held vector gets the memory ahead of a new buffer request
   assign req_ready_out = (state == ST_IDLE) && !vec_pend;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         wait_cnt <= 4'h0;
         cur <= '0;
         mode <= 1'b0;
         vec_owner <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (vec_pend) begin
                  cur <= '{wr: 1'b0, addr: vec_off[17:0], data: 8'h00};
                  vec_owner <= 1'b1;
                  mode <= dram_mode_in;
                  state <= dram_mode_in ? ST_ROW : ST_DATA;
                  wait_cnt <= 4'h0;
               end else if (req_valid_in) begin
                  cur <= req_in;
                  vec_owner <= 1'b0;
                  mode <= dram_mode_in; // Mode is frozen per access
                  state <= dram_mode_in ? ST_ROW : ST_DATA;
                  wait_cnt <= 4'h0;
               end
            end
            ST_ROW: begin
               state <= ST_COL;
            end
            ST_COL: begin
               state <= ST_DATA;
            end
            ST_DATA: begin
               // Two extra cycles cover the read-data synchroniser
               if (wait_cnt == 4'(ACCESS_CYC + 1)) begin
                  state <= ST_DONE;
               end else begin
                  wait_cnt <= wait_cnt + 4'h1;
               end
            end
            ST_DONE: begin
               if (vec_owner && !cur.wr) begin
                  cur.wr <= 1'b1; // Write back the corrected byte
                  cur.data <= rd_s2[7:0] ^ vec_pat;
                  state <= mode ? ST_ROW : ST_DATA;
                  wait_cnt <= 4'h0;
               end else begin
                  state <= ST_IDLE;
                  vec_owner <= 1'b0; // Correction finished, so ready may rise after the ack
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   logic active;
   assign active = (state != ST_IDLE) && (state != ST_DONE);

   // ----------------------------------------
   // Memory pins, registered
   // ----------------------------------------
   // Strobes low from their phase to the end of data; address muxed row then column
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         buffer_addr_low_out <= 16'h0000;
         addr_hi17_or_col_strobe_out <= 1'b1;
         addr_hi16_or_row_strobe_out <= 1'b1;
         mem_output_enable_n_out <= 1'b1;
         mem_write_enable_n_out <= 1'b1;
         buffer_data_bus_out <= 8'h00;
         buffer_data_bus_oe_n_out <= 1'b1;
         buffer_data_parity_out <= 1'b0;
         buffer_data_parity_oe_n_out <= 1'b1;
      end else begin
         if (mode) begin
            // Row half then column half on the 16 dedicated lines
            buffer_addr_low_out <= (state == ST_ROW) ? {7'h00, cur.addr[17:9]} : {7'h00, cur.addr[8:0]};
            addr_hi16_or_row_strobe_out <= !(active);
            addr_hi17_or_col_strobe_out <= !(state == ST_COL || state == ST_DATA);
            mem_output_enable_n_out <= !(active && !cur.wr);
         end else begin
            buffer_addr_low_out <= cur.addr[15:0];
            addr_hi16_or_row_strobe_out <= cur.addr[16];
            addr_hi17_or_col_strobe_out <= cur.addr[17];
            mem_output_enable_n_out <= !active; // Low on reads and writes
         end
         mem_write_enable_n_out <= !(state == ST_DATA && cur.wr);
         buffer_data_bus_out <= cur.data;
         buffer_data_parity_out <= odd_par(cur.data);
         buffer_data_bus_oe_n_out <= !(active && cur.wr);
         buffer_data_parity_oe_n_out <= !(active && cur.wr);
      end
   end

   // ----------------------------------------
   // Answer to the buffer manager
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_out <= 1'b0;
         rsp_out <= '0;
      end else begin
         rsp_valid_out <= (state == ST_DONE) && !vec_owner;
         if (state == ST_DONE && !vec_owner) begin
            rsp_out.data <= cur.wr ? cur.data : rd_s2[7:0];
            rsp_out.par_err <= !cur.wr && (rd_s2[8] != odd_par(rd_s2[7:0]));
         end
      end
   end

   // ----------------------------------------
   // Correction vector handling
   // ----------------------------------------
   logic rx_valid, rx_err;
   bmp_vec_t rx_vec;
   logic hold;

   bmp_vec_rx #(.PKT_BITS(`BMP_PKT_BITS)) u_rx (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .enable_in(corr_accept_ready_out),
      .vec_in(vec_s2),
      .frame_err_out(rx_err),
      .valid_out(rx_valid),
      .vec_out(rx_vec)
   );

   // Ready only with no packet pending and no correction in flight
   assign corr_accept_ready_out = !vec_pend && !hold && !vec_owner;

   // Packet held until applied to memory and consumer acks the report
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         vec_pend <= 1'b0;
         hold <= 1'b0;
         vec_off <= 24'h000000;
         vec_pat <= 8'h00;
         vec_valid_out <= 1'b0;
         vec_out <= '0;
         corr_fail_out <= 1'b0;
      end else begin
         corr_fail_out <= 1'b0;
         // Clear before set, so a packet landing in the same cycle is never lost
         if (state == ST_IDLE && vec_pend) begin
            vec_pend <= 1'b0;
         end
         if (rx_err) begin
            corr_fail_out <= 1'b1; // Protocol error
         end
         if (rx_valid) begin
            if (rx_vec.offset > 24'(BUF_TOP)) begin
               corr_fail_out <= 1'b1; // Correction out of buffer range fails
            end else begin
               vec_pend <= 1'b1;
               vec_off <= rx_vec.offset;
               vec_pat <= rx_vec.pattern;
            end
         end
         if (state == ST_DONE && vec_owner && cur.wr) begin
            hold <= 1'b1;
            vec_valid_out <= 1'b1;
            vec_out <= '{offset: vec_off, pattern: vec_pat};
         end else if (vec_valid_out && vec_ack_in) begin
            vec_valid_out <= 1'b0;
            hold <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sram_oe_every_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (!mode && state == ST_DATA) |=> !mem_output_enable_n_out)
      else $error("output enable not low in SRAM access");
   dram_oe_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (mode && cur.wr && $past(mode)) |=> mem_output_enable_n_out)
      else $error("output enable low in DRAM write");
   we_on_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_DATA && cur.wr) |=> !mem_write_enable_n_out)
      else $error("write enable not low during write");
   we_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (state == ST_IDLE) |=> mem_write_enable_n_out)
      else $error("write enable low while idle");
   wr_parity_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      !buffer_data_bus_oe_n_out |-> (^{buffer_data_parity_out, buffer_data_bus_out}) == 1'b1)
      else $error("write parity not odd");
   sram_hi_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (!mode && active) |=> addr_hi17_or_col_strobe_out == $past(cur.addr[17]))
      else $error("address bit 17 wrong in SRAM");
   dram_ras_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      (mode && state == ST_ROW) |=> !addr_hi16_or_row_strobe_out ##1 !addr_hi16_or_row_strobe_out)
      else $error("row strobe not held");
   ready_busy_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      rx_valid |=> (!corr_accept_ready_out || corr_fail_out))
      else $error("ready while packet held");
   cov_sram_wr_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) !mode && state == ST_DATA && cur.wr);
   cov_dram_rd_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) mode && state == ST_COL && !cur.wr);
   cov_vec_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) vec_valid_out);
   cov_err_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) corr_fail_out);
endmodule

// >>> sim/bmp_mem_model.sv
// Behavioural SRAM or DRAM buffer memory with a ninth parity bit per byte.
// Assumes registered strobes and address from the port on the same clock.
`timescale 1ns/1ns
module bmp_mem_model (
   input wire logic clk_in,
   input wire logic dram_in,
   input wire logic [15:0] addr_in,
   input wire logic hi17_in,
   input wire logic hi16_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [7:0] data_in,
   input wire logic par_in,
   input wire logic flip_par_in,
   output logic [7:0] data_out,
   output logic par_out
);
   logic [8:0] mem [0:262143];
   logic [8:0] row;
   logic [8:0] col;
   logic [8:0] last;
   logic ras_q = 1'b1;
   logic cas_q = 1'b1;
   logic [17:0] a;
   logic sel;
   logic rd;
   // DRAM address is only valid once both strobes have latched, one edge late
   assign a = dram_in ? {row, col} : {hi17_in, hi16_in, addr_in};
   assign sel = !dram_in || (!hi17_in && !cas_q);
   assign rd = !oe_n_in && we_n_in && sel;
   always @(posedge clk_in) begin
      ras_q <= hi16_in;
      cas_q <= hi17_in;
      if (!hi16_in && ras_q) row <= addr_in[8:0];
      if (!hi17_in && cas_q) col <= addr_in[8:0];
      if (!we_n_in && sel) mem[a] <= {par_in, data_in};
      if (rd) last <= mem[a];
   end
   // Released bus shows the inverse of the last byte, never a stale copy
   assign data_out = rd ? mem[a][7:0] : ~last[7:0];
   assign par_out = rd ? mem[a][8] ^ flip_par_in : ~last[8];
endmodule

// >>> sim/bmp_port_tb.sv
// Self-checking bench for the buffer memory port with a memory model.
// Assumes the design package and constant header are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module bmp_port_tb;
   import bmp_pkg::*;
   logic clk_sys_in, arst_n_in, dram_mode, req_valid, vec_ack, vector_in, flip_par;
   bmp_req_t req;
   logic req_ready_out, rsp_valid_out, vec_valid_out, hi17, hi16, oe_n, we_n;
   logic bus_oe_n, par_oe_n, dev_par, mem_par, corr_accept_ready_out, corr_fail_out;
   bmp_rsp_t rsp_out;
   bmp_vec_t vec_out;
   logic [15:0] addr_low;
   logic [7:0] dev_data, mem_data;
   int err_count, check_count;
   int cnt [5];
   int b [5];
   // ----------------------------------------
   // Design, memory and resolved data bus
   // ----------------------------------------
   bmp_port #(.ACCESS_CYC(3)) u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .dram_mode_in(dram_mode), .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .vec_ack_in(vec_ack), .vec_valid_out(vec_valid_out),
      .vec_out(vec_out), .buffer_addr_low_out(addr_low), .addr_hi17_or_col_strobe_out(hi17),
      .addr_hi16_or_row_strobe_out(hi16), .mem_output_enable_n_out(oe_n), .mem_write_enable_n_out(we_n),
      .buffer_data_bus_in(bus_oe_n ? mem_data : dev_data), .buffer_data_bus_out(dev_data),
      .buffer_data_bus_oe_n_out(bus_oe_n), .buffer_data_parity_in(par_oe_n ? mem_par : dev_par),
      .buffer_data_parity_out(dev_par), .buffer_data_parity_oe_n_out(par_oe_n), .vector_in(vector_in),
      .corr_accept_ready_out(corr_accept_ready_out), .corr_fail_out(corr_fail_out));
   bmp_mem_model u_mem (.clk_in(clk_sys_in), .dram_in(dram_mode), .addr_in(addr_low), .hi17_in(hi17),
      .hi16_in(hi16), .oe_n_in(oe_n), .we_n_in(we_n), .data_in(dev_data), .par_in(dev_par),
      .flip_par_in(flip_par), .data_out(mem_data), .par_out(mem_par));
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Pin activity counters; tests compare deltas so no clearing race arises
   always @(posedge clk_sys_in) begin
      if (!we_n) cnt[0]++;
      if (!we_n && !oe_n) cnt[1]++;
      if (!oe_n) cnt[2]++;
      if (!hi16) cnt[3]++;
      if (!hi17) cnt[4]++;
   end
   // ----------------------------------------
   // Bus and vector tasks
   // ----------------------------------------
   task automatic access(input logic dm, input logic wr, input logic [17:0] ad, input logic [7:0] d);
      int n;
      @(posedge clk_sys_in);
      #1;
      dram_mode = dm;
      req = '{wr: wr, addr: ad, data: d};
      req_valid = 1'b1;
      n = 0;
      while (req_ready_out !== 1'b1 && n < 100) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      @(posedge clk_sys_in);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid_out !== 1'b1 && n < 50) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      `CHK(rsp_valid_out, 1'b1);
   endtask
   task automatic send_vec(input logic [23:0] off, input logic [7:0] pat, input logic stop);
      logic [33:0] f;
      int n;
      f = {1'b1, off, pat, stop};
      n = 0;
      while (corr_accept_ready_out !== 1'b1 && n < 100) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      for (int i = 33; i >= 0; i--) begin
         vector_in = f[i];
         @(posedge clk_sys_in);
         #1;
      end
      vector_in = 1'b0;
   endtask
   // Level outputs picked by index, so no reference to a port-driven variable is needed
   function automatic logic pick(input int k);
      case (k)
         0: pick = vec_valid_out;
         1: pick = corr_accept_ready_out;
         default: pick = corr_fail_out;
      endcase
   endfunction
   task automatic wait_hi(input int k, input int lim);
      int n;
      n = 0;
      while (pick(k) !== 1'b1 && n < lim) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_sram;
      b = cnt;
      access(1'b0, 1'b1, 18'h31234, 8'hA5);
      `CHK(cnt[1] - b[1] == cnt[0] - b[0] && cnt[0] > b[0], 1'b1);
      `CHK({hi17, hi16}, 2'b11);
      `CHK(u_mem.mem[18'h31234], {~^8'hA5, 8'hA5});
      b = cnt;
      access(1'b0, 1'b0, 18'h31234, 8'h00);
      `CHK(rsp_out, {8'hA5, 1'b0});
      `CHK(cnt[2] > b[2] && cnt[0] == b[0], 1'b1);
      $display("test sram done");
   endtask
   task automatic t_dram;
      b = cnt;
      access(1'b1, 1'b1, 18'h20155, 8'h3C);
      `CHK(cnt[1] == b[1] && cnt[0] > b[0], 1'b1);
      `CHK(cnt[3] > b[3] && cnt[4] > b[4], 1'b1);
      `CHK(u_mem.mem[18'h20155], {~^8'h3C, 8'h3C});
      b = cnt;
      access(1'b1, 1'b0, 18'h20155, 8'h00);
      `CHK(rsp_out, {8'h3C, 1'b0});
      `CHK(cnt[2] > b[2], 1'b1);
      $display("test dram done");
   endtask
   task automatic t_parity;
      flip_par = 1'b1;
      access(1'b0, 1'b0, 18'h31234, 8'h00);
      flip_par = 1'b0;
      `CHK(rsp_out, {8'hA5, 1'b1});
      $display("test parity done");
   endtask
   task automatic t_vec;
      access(1'b0, 1'b1, 18'h00100, 8'h0F);
      send_vec(24'h000100, 8'hF0, 1'b1);
      wait_hi(0, 200);
      `CHK(vec_valid_out, 1'b1);
      `CHK(vec_out, {24'h000100, 8'hF0});
      `CHK(corr_accept_ready_out, 1'b0);
      vec_ack = 1'b1;
      @(posedge clk_sys_in);
      #1;
      vec_ack = 1'b0;
      wait_hi(1, 5);
      `CHK(corr_accept_ready_out, 1'b1);
      access(1'b0, 1'b0, 18'h00100, 8'h00);
      `CHK(rsp_out, {8'hFF, 1'b0});
      $display("test vector done");
   endtask
   task automatic t_vfail(input logic [23:0] off, input logic stop);
      send_vec(off, 8'h01, stop);
      wait_hi(2, 200);
      `CHK(corr_fail_out, 1'b1);
      repeat (60) @(posedge clk_sys_in);
      #1;
      vec_ack = vec_valid_out;
      @(posedge clk_sys_in);
      #1;
      vec_ack = 1'b0;
      $display("test vector fail done");
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
   initial begin
      arst_n_in = 1'b0;
      dram_mode = 1'b0;
      req_valid = 1'b0;
      req = '0;
      vec_ack = 1'b0;
      vector_in = 1'b0;
      flip_par = 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      arst_n_in = 1'b1;
      repeat (5) @(posedge clk_sys_in);
      #1;
      t_sram();
      t_dram();
      t_parity();
      t_vec();
      t_vfail(24'h000200, 1'b0);
      t_vfail(24'h040000, 1'b1);
      end_of_test();
   end
endmodule
